// file: bench/itcs_osc_model.sv
// Model of the three oscillator sources
`timescale 1ns/1ps
module itcs_osc_model (
	output logic o_sys,
	output logic o_hoco,
	output logic o_low
);
	// Edges land between clock edges, so measured periods are exact
	initial {o_sys, o_hoco, o_low} = 3'b000;
	always #30 o_sys = ~o_sys;
	always #20 o_hoco = ~o_hoco;
	always #150 o_low = ~o_low;
endmodule : itcs_osc_model

// file: bench/itcs_top_sva.sv
// Assertions on the clock-select block ports
`timescale 1ns/1ps
`include "itcs_defines.svh"
module itcs_top_sva (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [`ITCS_ADDR_W-1:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic o_timers_reset,
	input wire logic o_rtc_count_en,
	input wire logic o_it_count_en,
	input wire logic o_gpt_lowosc_allowed,
	input wire logic [15:0] o_it_control,
	input wire logic o_bad_divider
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	logic low_r;
	wire gw = i_wr && i_addr == `ITCS_OFS_GATE;
	wire cw = i_addr == `ITCS_OFS_ITCTL;
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			low_r <= 1'b0;
		end else if (i_wr && i_addr == `ITCS_OFS_SRCMODE) begin
			low_r <= i_wdata[4];
		end
	end
	a_reset_vals: assert property ($fell(i_reset) |-> o_timers_reset && o_it_control == `ITCS_RST_ITCTL)
		else $error("reset values");
	a_gate_open: assert property (gw && i_wdata[7] |=> ##1 !o_timers_reset)
		else $error("gate open");
	a_gate_close: assert property (gw && !i_wdata[7] |=> ##1 o_timers_reset)
		else $error("gate close");
	a_held_quiet: assert property (o_timers_reset && $past(o_timers_reset, 3) |-> !o_rtc_count_en && !o_it_count_en)
		else $error("count while held");
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("stray read data");
	a_ctl_frozen: assert property (i_wr && cw && o_timers_reset && !$past(gw) |=> $stable(o_it_control))
		else $error("control written");
	a_ctl_default: assert property (i_rd && cw && o_timers_reset && $past(o_timers_reset) |=> o_rdata == 16'h7fff)
		else $error("control read");
	a_lowspd_mirror: assert property (!$past(i_wr) && !$past(i_wr, 2) |-> o_gpt_lowosc_allowed == low_r)
		else $error("low-speed mirror");
	c_rtc: cover property (o_rtc_count_en);
	c_low: cover property (o_gpt_lowosc_allowed && o_it_count_en);
	c_bad: cover property (o_bad_divider);
endmodule : itcs_top_sva
bind itcs_top itcs_top_sva u_itcs_top_sva (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
	.o_timers_reset, .o_rtc_count_en, .o_it_count_en, .o_gpt_lowosc_allowed, .o_it_control, .o_bad_divider);

// file: bench/testbench.sv
// Self-checking bench for the clock-select block
`timescale 1ns/1ps
`include "itcs_defines.svh"
module testbench;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [`ITCS_ADDR_W-1:0] i_addr = '0;
	logic [15:0] i_wdata = '0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic sys, hoco, low, o_timers_reset, o_rtc_count_en, o_it_count_en, o_gpt_lowosc_allowed, o_bad_divider;
	logic [15:0] o_rdata, o_it_control;
	int fail_count = 0;
	int n_tests = 0;
	// Only listed settings; sources run faster than real parts to keep the run short
	logic [7:0] sel [4] = '{8'h00, 8'h21, 8'hc2, 8'h83};
	int per [4] = '{732, 3660, 2928, 3904};
	always #5 i_clk = ~i_clk;
	itcs_osc_model u_osc (.o_sys(sys), .o_hoco(hoco), .o_low(low));
	itcs_top u_itcs_top (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .i_sysclk_tick(sys),
		.i_hoco_tick(hoco), .i_lowosc_tick(low), .o_rdata, .o_timers_reset, .o_rtc_count_en,
		.o_it_count_en, .o_gpt_lowosc_allowed, .o_it_control, .o_bad_divider);
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic bus(logic w, logic r, logic [19:0] a, logic [15:0] d);
		i_wr <= w;
		i_rd <= r;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		#1;
	endtask : bus
	task automatic idle(int n);
		repeat (n) bus(1'b0, 1'b0, '0, '0);
	endtask : idle
	task automatic wr(logic [19:0] a, logic [15:0] d);
		bus(1'b1, 1'b0, a, d);
		idle(3);
	endtask : wr
	task automatic rd(string n, logic [19:0] a, logic [15:0] e);
		bus(1'b0, 1'b1, a, '0);
		chk(n, e, o_rdata);
		idle(1);
	endtask : rd
	task automatic per_chk(string n, logic it, int e);
		int t;
		int s;
		int k;
		t = 0;
		s = 0;
		k = 0;
		// First pulse may follow a partial count, so time the second interval
		while (k < 3 && t < 20000) begin
			idle(1);
			t++;
			if ((it ? o_it_count_en : o_rtc_count_en) === 1'b1) begin
				k++;
				if (k == 2) s = t;
			end
		end
		chk(n, 16'(e), 16'(t - s));
	endtask : per_chk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	initial begin
		#1000000;
		fail_count++;
		report_and_stop;
	end
	initial begin
		repeat (10) @(posedge i_clk);
		#1;
		i_reset <= 1'b0;
		rd("gate", `ITCS_OFS_GATE, 16'h0);
		rd("srcmode", `ITCS_OFS_SRCMODE, 16'h0);
		rd("divsel", `ITCS_OFS_DIVSEL, 16'h0);
		chk("held", 16'h1, o_timers_reset);
		wr(`ITCS_OFS_ITCTL, 16'h8001);
		rd("ctl off", `ITCS_OFS_ITCTL, 16'h7fff);
		wr(`ITCS_OFS_GATE, 16'h0080);
		chk("held", 16'h0, o_timers_reset);
		wr(`ITCS_OFS_ITCTL, 16'h8001);
		rd("ctl on", `ITCS_OFS_ITCTL, 16'h8001);
		chk("itctl", 16'h8001, o_it_control);
		rd("unmapped", 20'h00000, 16'h0);
		per_chk("it", 1'b1, 732);
		for (int i = 0; i < 4; i++) begin
			wr(`ITCS_OFS_DIVSEL, {8'h00, sel[i]});
			rd("divsel", `ITCS_OFS_DIVSEL, {8'h00, sel[i]});
			per_chk("rtc", 1'b0, per[i]);
		end
		wr(`ITCS_OFS_DIVSEL, 16'h0060);
		chk("bad", 16'h1, o_bad_divider);
		wr(`ITCS_OFS_DIVSEL, 16'h0);
		wr(`ITCS_OFS_SRCMODE, 16'h0010);
		chk("gpt", 16'h1, o_gpt_lowosc_allowed);
		per_chk("low", 1'b1, 30);
		wr(`ITCS_OFS_SRCMODE, 16'h0);
		chk("gpt", 16'h0, o_gpt_lowosc_allowed);
		wr(`ITCS_OFS_GATE, 16'h0);
		chk("held", 16'h1, o_timers_reset);
		chk("itctl", 16'h7fff, o_it_control);
		// Mid-run reset must clear the gate and divider select registers again
		wr(`ITCS_OFS_DIVSEL, 16'h0083);
		wr(`ITCS_OFS_GATE, 16'h0080);
		i_reset <= 1'b1;
		idle(2);
		i_reset <= 1'b0;
		rd("gate", `ITCS_OFS_GATE, 16'h0);
		rd("divsel", `ITCS_OFS_DIVSEL, 16'h0);
		chk("itctl", 16'h7fff, o_it_control);
		report_and_stop;
	end
endmodule : testbench

// file: core/itcs_defines.svh
// Register offsets, field positions, reset values and divider counts
`ifndef ITCS_DEFINES_SVH
`define ITCS_DEFINES_SVH
`define ITCS_ADDR_W 20
`define ITCS_OFS_GATE 20'hf00f0
`define ITCS_OFS_SRCMODE 20'hf00f3
`define ITCS_OFS_DIVSEL 20'hf02d8
`define ITCS_OFS_ITCTL 20'hfff90
`define ITCS_OFS_STATUS 20'hf02e0
`define ITCS_RST_BYTE 8'h00
`define ITCS_RST_ITCTL 16'h7fff
`define ITCS_BIT_TCLK_EN 7
`define ITCS_BIT_LOWSPD 4
`define ITCS_BIT_DIVSRC 7
`define ITCS_GATE_WMASK 8'ha7
`define ITCS_SRCMODE_WMASK 8'h10
`define ITCS_DIVSEL_WMASK 8'he3
`define ITCS_DIV1_A 9'd122
`define ITCS_DIV1_B 9'd305
`define ITCS_DIV1_C 9'd183
`endif

// file: core/itcs_div_if.sv
// Carrier between the selector and the cascaded divider
`timescale 1ns/1ps
interface itcs_div_if;
	logic run;
	logic src_tick;
	logic [1:0] div1_sel;
	logic [1:0] div2_sel;
	logic out_tick;
	logic bad_sel;
	modport ctrl(output run, output src_tick, output div1_sel, output div2_sel, input out_tick, input bad_sel);
	modport div(input run, input src_tick, input div1_sel, input div2_sel, output out_tick, output bad_sel);
endinterface : itcs_div_if

// file: core/itcs_divider.sv
// Cascaded first and second divider producing a count enable
`timescale 1ns/1ps
`include "itcs_defines.svh"
module itcs_divider
	import itcs_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	itcs_div_if.div d
);
	function automatic logic [8:0] div1_len(input logic [1:0] sel);
		case (sel)
			2'b00: div1_len = `ITCS_DIV1_A;
			2'b01: div1_len = `ITCS_DIV1_B;
			2'b10: div1_len = `ITCS_DIV1_C;
			default: div1_len = 9'd0;
		endcase
	endfunction : div1_len

	itcs_div_e state_r;
	itcs_div_e state_nxt;
	logic [8:0] cnt1_r;
	logic [2:0] cnt2_r;
	logic out_r;
	wire logic [8:0] len1 = div1_len(d.div1_sel);
	wire logic [2:0] last2 = 3'((4'h1 << d.div2_sel) - 4'h1);
	wire logic wrap1 = d.src_tick && (cnt1_r >= len1 - 9'd1);
	wire logic wrap2 = wrap1 && (cnt2_r >= last2);
	wire logic active = (state_r == ITCS_DIV_RUN);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ITCS_DIV_IDLE: state_nxt = !d.run ? ITCS_DIV_IDLE : (len1 == 9'd0) ? ITCS_DIV_BAD : ITCS_DIV_RUN;
			ITCS_DIV_RUN: state_nxt = !d.run ? ITCS_DIV_HOLD : (len1 == 9'd0) ? ITCS_DIV_BAD : ITCS_DIV_RUN;
			ITCS_DIV_HOLD: state_nxt = ITCS_DIV_IDLE;
			ITCS_DIV_BAD: state_nxt = (!d.run || len1 != 9'd0) ? ITCS_DIV_IDLE : ITCS_DIV_BAD;
			default: state_nxt = ITCS_DIV_IDLE;
		endcase
	end

	// Counters restart from zero only outside the run state, so a selection change while running can yield a short count period
	always_ff @(posedge i_clk) begin
		if (i_reset || !active) begin
			cnt1_r <= 9'd0;
			cnt2_r <= 3'd0;
			out_r <= 1'b0;
		end else begin
			out_r <= wrap2;
			if (d.src_tick) begin
				cnt1_r <= wrap1 ? 9'd0 : cnt1_r + 9'd1;
				if (wrap1) begin
					cnt2_r <= wrap2 ? 3'd0 : cnt2_r + 3'd1;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_r <= ITCS_DIV_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign d.out_tick = out_r;
	assign d.bad_sel = (state_r == ITCS_DIV_BAD);
endmodule : itcs_divider

// file: core/itcs_pkg.sv
// Types shared by the clock-select block
package itcs_pkg;
	typedef logic [7:0] itcs_byte_t;
	typedef enum logic [3:0] {
		ITCS_DIV_IDLE = 4'h1,
		ITCS_DIV_RUN = 4'h2,
		ITCS_DIV_HOLD = 4'h4,
		ITCS_DIV_BAD = 4'h8
	} itcs_div_e;
endpackage : itcs_pkg

// file: core/itcs_top.sv
// Interval timer / real-time clock gating and count clock selection
// Notes on behaviour
// - Gate bit 7 low stops timer clock and holds both timers in reset.
// - Gate bit 7 high supplies clock; timer registers become readable and writable.
// - With gate low, control writes ignored, reads give default; others stay accessible.
// - Reset clears gate, source mode and divider select registers to zero.
// - Low-speed select zero: divided clock counts both timers.
// - Low-speed select one: interval timer runs from low-speed oscillator.
// - Low-speed oscillator allowed for general timer only when select is one.
// - Divider select bit 7 picks system clock (0) or on-chip oscillator (1).
// - Bits 6:5 divide by 122, 305, 183; code 11 prohibited.
// - Bits 1:0 divide further by 1, 2, 4 or 8.
`timescale 1ns/1ps
`include "itcs_defines.svh"
module itcs_top
	import itcs_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [`ITCS_ADDR_W-1:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_sysclk_tick,
	input wire logic i_hoco_tick,
	input wire logic i_lowosc_tick,
	output logic [15:0] o_rdata,
	output logic o_timers_reset,
	output logic o_rtc_count_en,
	output logic o_it_count_en,
	output logic o_gpt_lowosc_allowed,
	output logic [15:0] o_it_control,
	output logic o_bad_divider
);
	itcs_byte_t gate_r;
	itcs_byte_t srcmode_r;
	itcs_byte_t divsel_r;
	logic [15:0] itctl_r;
	logic [15:0] rdata_r;
	logic treset_r;
	logic rtc_en_r;
	logic it_en_r;
	logic gpt_r;
	logic bad_r;
	logic [1:0] sys_sync_r;
	logic [1:0] hoco_sync_r;
	logic [1:0] low_sync_r;
	logic sys_prev_r;
	logic hoco_prev_r;
	logic low_prev_r;

	itcs_div_if dvi();

	// Source pins come from foreign oscillators, so each is synchronised first
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sys_sync_r <= 2'b00;
			hoco_sync_r <= 2'b00;
			low_sync_r <= 2'b00;
			sys_prev_r <= 1'b0;
			hoco_prev_r <= 1'b0;
			low_prev_r <= 1'b0;
		end else begin
			sys_sync_r <= {sys_sync_r[0], i_sysclk_tick};
			hoco_sync_r <= {hoco_sync_r[0], i_hoco_tick};
			low_sync_r <= {low_sync_r[0], i_lowosc_tick};
			sys_prev_r <= sys_sync_r[1];
			hoco_prev_r <= hoco_sync_r[1];
			low_prev_r <= low_sync_r[1];
		end
	end

	wire logic sys_rise = sys_sync_r[1] && !sys_prev_r;
	wire logic hoco_rise = hoco_sync_r[1] && !hoco_prev_r;
	wire logic low_rise = low_sync_r[1] && !low_prev_r;

	wire logic tclk_en = gate_r[`ITCS_BIT_TCLK_EN];
	wire logic low_sel = srcmode_r[`ITCS_BIT_LOWSPD];
	wire logic hoco_sel = divsel_r[`ITCS_BIT_DIVSRC];

	wire logic hit_gate = (i_addr == `ITCS_OFS_GATE);
	wire logic hit_src = (i_addr == `ITCS_OFS_SRCMODE);
	wire logic hit_div = (i_addr == `ITCS_OFS_DIVSEL);
	wire logic hit_itc = (i_addr == `ITCS_OFS_ITCTL);
	wire logic hit_sts = (i_addr == `ITCS_OFS_STATUS);

	wire logic wr_gate = i_wr && hit_gate;
	wire logic wr_src = i_wr && hit_src;
	wire logic wr_div = i_wr && hit_div;
	wire logic wr_itc = i_wr && hit_itc && tclk_en;

	wire logic [15:0] itc_view = tclk_en ? itctl_r : `ITCS_RST_ITCTL;
	wire logic [15:0] status_word = {11'h000, bad_r, gpt_r, it_en_r, rtc_en_r, treset_r};
	wire logic [15:0] rd_mux =
		hit_gate ? {8'h00, gate_r} :
		hit_src ? {8'h00, srcmode_r} :
		hit_div ? {8'h00, divsel_r} :
		hit_itc ? itc_view :
		hit_sts ? status_word : 16'h0000;

	assign dvi.run = tclk_en;
	assign dvi.src_tick = hoco_sel ? hoco_rise : sys_rise;
	assign dvi.div1_sel = divsel_r[6:5];
	assign dvi.div2_sel = divsel_r[1:0];

	itcs_divider u_div (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.d(dvi)
	);

	// Register file
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			gate_r <= `ITCS_RST_BYTE;
			srcmode_r <= `ITCS_RST_BYTE;
			divsel_r <= `ITCS_RST_BYTE;
		end else begin
			if (wr_gate) begin
				gate_r <= i_wdata[7:0] & `ITCS_GATE_WMASK;
			end
			if (wr_src) begin
				srcmode_r <= i_wdata[7:0] & `ITCS_SRCMODE_WMASK;
			end
			if (wr_div) begin
				divsel_r <= i_wdata[7:0] & `ITCS_DIVSEL_WMASK;
			end
		end
	end

	// Timer control is held at its default while the gate is closed
	always_ff @(posedge i_clk) begin
		if (i_reset || !tclk_en) begin
			itctl_r <= `ITCS_RST_ITCTL;
		end else if (wr_itc) begin
			itctl_r <= i_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= i_rd ? rd_mux : 16'h0000;
		end
	end

	// Count enables; low-speed pulse bypasses the divider for the interval timer only
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			treset_r <= 1'b1;
			rtc_en_r <= 1'b0;
			it_en_r <= 1'b0;
			gpt_r <= 1'b0;
			bad_r <= 1'b0;
		end else begin
			treset_r <= !tclk_en;
			rtc_en_r <= tclk_en && !low_sel && dvi.out_tick;
			it_en_r <= tclk_en && (low_sel ? low_rise : dvi.out_tick);
			gpt_r <= low_sel;
			bad_r <= dvi.bad_sel;
		end
	end

	assign o_rdata = rdata_r;
	assign o_timers_reset = treset_r;
	assign o_rtc_count_en = rtc_en_r;
	assign o_it_count_en = it_en_r;
	assign o_gpt_lowosc_allowed = gpt_r;
	assign o_it_control = itctl_r;
	assign o_bad_divider = bad_r;
endmodule : itcs_top
